// [core/tprm_mailbox.sv]
// Two-port register mailbox between backplane host and local processor
// Functional notes
// R1: In debug mode, host setting command bit 15 exits debug and returns to idle.
// R2: Debug command bit 4 restores saved context and resumes the program.
// R3: Debug command bit 3 inits the bus, resets I/O, starts at parameter b.
// R4: Start clears status, interrupt, error, float registers and memory management bits.
// R5: Debug command bit 2 deposits parameter a into the open location.
// R6: Debug bit 1 examines register coded in parameter b into parameter a.
// R7: Undefined register code sets command error bit 15 of the error word.
// R8: Debug bit 0 examines 22-bit memory address, high from a, low from b.
// R9: Error word is read-only from the host, read/write locally.
// R10: Error bit 15 on command failure, bit 14 on transfer controller abort.
// R11: Fatal error sets bit 5; then only the hard-reset bit is obeyed (code accepts and decodes a whole host command word that has bit 14 set).
// R12: Stack violation sets bit 3; in kernel mode it is fatal.
// R13: Error field 2:0 shows board state encoding.
// R14: Host sends nothing when unavailable or dedicated, only debug commands in debug.
// R15: Parameter words a and b are read/write from both sides.
// R16: After reset, parameter b holds the boot switch in bits 7:4, zeros elsewhere.
// R17: Local side writes all words; host cannot write words one, five and nine.
// R18: Host write to words 4, 8, 12 raises enabled level 5 interrupt, vectors 120/124/134.
// R19: Id switch 0 and 1 mean standalone, 2 to 15 mean host bus use.
// R20: DMA failure sets detail bit 3 hung, 4 nonexistent memory, 5 mismatch.
// R21: Clock failure sets detail bit 1 unmasked, 2 none, 3 cannot disable.
// R22: Control command bit 3 enters remote debug mode.
// R23: Command word is cleared after any command completes.
// R24: Simultaneous host and local writes to one word: host wins.
`timescale 1ns/10ps

module tprm_mailbox #(
	parameter int WORDS = tprm_pkg::NUM_WORDS
) (
	// Clock and reset
	input  wire logic                        SYS_CLK,
	input  wire logic                        RST,
	// Host side port
	input  wire tprm_pkg::tprm_access_t      HOST_ACC,
	output logic      [tprm_pkg::DATA_W-1:0] HOST_RDATA,
	output logic                             HOST_HARD_RESET,
	// Local processor port
	input  wire tprm_pkg::tprm_access_t      LOCAL_ACC,
	output logic      [tprm_pkg::DATA_W-1:0] LOCAL_RDATA,
	// Debug actions and their completion
	output tprm_pkg::tprm_action_t           DBG_ACTION,
	output logic                             DBG_CLEAR_CONTEXT,
	input  wire logic                        DBG_DONE,
	input  wire logic                        DBG_RESULT_VALID,
	input  wire logic [tprm_pkg::DATA_W-1:0] DBG_RESULT,
	// Control-register commands for firmware
	output logic      [tprm_pkg::DATA_W-1:0] CTRL_COMMAND,
	input  wire logic                        CMD_DONE,
	// Events from the local side
	input  wire tprm_pkg::tprm_events_t      EVENTS,
	input  wire logic [2:0]                  STATE_SET,
	input  wire logic                        STATE_SET_VALID,
	// Straps (pins)
	input  wire logic [3:0]                  BOOT_SWITCH,
	input  wire logic [3:0]                  ID_SWITCH,
	output logic                             STANDALONE,
	// Mailbox interrupt enables and request
	input  wire logic [2:0]                  MBOX_IRQ_EN,
	input  wire logic [2:0]                  MBOX_RQ_CLEAR,
	output logic      [2:0]                  MBOX_RQ,
	output logic                             IRQ_REQ,
	output logic      [2:0]                  IRQ_LEVEL,
	output logic      [8:0]                  IRQ_VECTOR
);

	localparam int DW = tprm_pkg::DATA_W;
	localparam int AW = tprm_pkg::ADDR_W;

	initial begin
		if (WORDS != 16) begin
			$error("tprm_mailbox: sixteen words are required");
		end
	end

	// Strap synchronisers
	logic [3:0] boot_meta_reg;
	logic [3:0] boot_sync_reg;
	logic [3:0] id_meta_reg;
	logic [3:0] id_sync_reg;
	logic [1:0] strap_cnt_reg;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			boot_meta_reg <= 4'h0;
			boot_sync_reg <= 4'h0;
			id_meta_reg   <= 4'h0;
			id_sync_reg   <= 4'h0;
		end else begin
			boot_meta_reg <= BOOT_SWITCH;
			boot_sync_reg <= boot_meta_reg;
			id_meta_reg   <= ID_SWITCH;
			id_sync_reg   <= id_meta_reg;
		end
	end

	// Counts edges until synchronised straps are valid
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			strap_cnt_reg <= 2'h0;
		end else if (strap_cnt_reg != 2'h3) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
		end
	end

	wire strap_load = (strap_cnt_reg == 2'h2);

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			STANDALONE <= 1'b1;
		end else begin
			STANDALONE <= (id_sync_reg <= tprm_pkg::ID_STANDALONE_MAX); // R19
		end
	end

	// Special words held in flops
	logic [DW-1:0] command_word_reg;
	logic [DW-1:0] error_state_word_reg;
	logic [DW-1:0] parameter_word_a_reg;
	logic [DW-1:0] parameter_word_b_reg;
	logic          debug_mode_reg;

	wire is_special_h = (HOST_ACC.addr <= tprm_pkg::IDX_PARAM_B);
	wire is_special_l = (LOCAL_ACC.addr <= tprm_pkg::IDX_PARAM_B);
	wire fatal_now    = error_state_word_reg[tprm_pkg::ERR_FATAL_BIT];

	// Host write permission
	logic host_wr_ok;
	always_comb begin
		host_wr_ok = HOST_ACC.wr;
		if (HOST_ACC.addr == tprm_pkg::IDX_ERROR ||
		    HOST_ACC.addr == tprm_pkg::IDX_MBOX_5 ||
		    HOST_ACC.addr == tprm_pkg::IDX_MBOX_9) begin
			host_wr_ok = 1'b0; // R9 R17
		end
		if (fatal_now && HOST_ACC.addr == tprm_pkg::IDX_COMMAND &&
		    !HOST_ACC.wdata[tprm_pkg::CMD_HARD_RST_BIT]) begin
			host_wr_ok = 1'b0; // R11
		end
	end

	wire host_cmd_wr  = host_wr_ok && HOST_ACC.addr == tprm_pkg::IDX_COMMAND;
	wire local_wr_ok  = LOCAL_ACC.wr &&
	                    !(host_wr_ok && HOST_ACC.addr == LOCAL_ACC.addr); // R24

	// Hard reset pulse, honoured even after a fatal error
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			HOST_HARD_RESET <= 1'b0;
		end else begin
			HOST_HARD_RESET <= HOST_ACC.wr && HOST_ACC.addr == tprm_pkg::IDX_COMMAND &&
			                   HOST_ACC.wdata[tprm_pkg::CMD_HARD_RST_BIT]; // R11
		end
	end

	// Decoded debug command from a host write
	wire [DW-1:0] cw = HOST_ACC.wdata;
	wire dbg_exit   = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_EXIT_BIT];
	wire dbg_resume = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_RESUME_BIT];
	wire dbg_start  = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_START_BIT];
	wire dbg_dep    = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_DEPOSIT_BIT];
	wire dbg_exreg  = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_EX_REG_BIT];
	wire dbg_exmem  = debug_mode_reg && host_cmd_wr && cw[tprm_pkg::CMD_EX_MEM_BIT];
	wire ctl_enter  = !debug_mode_reg && host_cmd_wr && !cw[tprm_pkg::CMD_EXIT_BIT] &&
	                  cw[tprm_pkg::CMD_START_BIT];
	wire reg_bad    = parameter_word_b_reg > tprm_pkg::REG_CODE_PSW;

	// Debug mode flag
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			debug_mode_reg <= 1'b0;
		end else if (ctl_enter) begin
			debug_mode_reg <= 1'b1; // R22
		end else if (dbg_exit || dbg_resume || dbg_start) begin
			debug_mode_reg <= 1'b0; // R1 R2 R3
		end
	end

	// Debug action strobes, one cycle after the command write
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			DBG_ACTION        <= '0;
			DBG_CLEAR_CONTEXT <= 1'b0;
		end else begin
			DBG_ACTION.exit_debug <= dbg_exit; // R1
			DBG_ACTION.resume     <= dbg_resume && !dbg_exit; // R2
			DBG_ACTION.start      <= dbg_start && !dbg_exit; // R3
			DBG_ACTION.deposit    <= dbg_dep && !dbg_exit; // R5
			DBG_ACTION.ex_reg     <= dbg_exreg && !dbg_exit && !reg_bad; // R6
			DBG_ACTION.ex_mem     <= dbg_exmem && !dbg_exit; // R8
			DBG_ACTION.value      <= parameter_word_a_reg; // R5
			DBG_ACTION.reg_sel    <= parameter_word_b_reg; // R3 R6
			DBG_ACTION.mem_addr   <= {parameter_word_a_reg[tprm_pkg::MEM_HI_W-1:0],
			                          parameter_word_b_reg}; // R8
			DBG_CLEAR_CONTEXT     <= dbg_start && !dbg_exit; // R4
		end
	end

	// Control commands presented to firmware outside debug mode
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			CTRL_COMMAND <= 16'h0000;
		end else begin
			CTRL_COMMAND <= debug_mode_reg ? 16'h0000 : command_word_reg;
		end
	end

	// Command word
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			command_word_reg <= 16'h0000;
		end else if (host_cmd_wr) begin
			command_word_reg <= HOST_ACC.wdata; // R24
		end else if (local_wr_ok && LOCAL_ACC.addr == tprm_pkg::IDX_COMMAND) begin
			command_word_reg <= LOCAL_ACC.wdata;
		end else if (DBG_DONE || CMD_DONE) begin
			command_word_reg <= 16'h0000; // R23
		end
	end

	// Error and state word; hardware sets win over local clears
	logic [DW-1:0] err_next;
	always_comb begin
		err_next = error_state_word_reg;
		if (local_wr_ok && LOCAL_ACC.addr == tprm_pkg::IDX_ERROR) begin
			err_next = LOCAL_ACC.wdata; // R9
		end
		if (STATE_SET_VALID) begin
			err_next[tprm_pkg::ERR_STATE_LSB +: tprm_pkg::ERR_STATE_W] = STATE_SET; // R13
		end
		if (EVENTS.cmd_fail ||
		    (reg_bad && dbg_exreg && !dbg_exit)) begin
			err_next[tprm_pkg::ERR_CMD_BIT] = 1'b1; // R7 R10
		end
		if (EVENTS.xfer_abort) begin
			err_next[tprm_pkg::ERR_XFER_BIT] = 1'b1; // R10
		end
		if (EVENTS.stack_violation) begin
			err_next[tprm_pkg::ERR_STACK_BIT] = 1'b1; // R12
		end
		if (EVENTS.fatal || (EVENTS.stack_violation && EVENTS.kernel_mode)) begin
			err_next[tprm_pkg::ERR_FATAL_BIT] = 1'b1; // R11 R12
			err_next[tprm_pkg::ERR_STATE_LSB +: tprm_pkg::ERR_STATE_W] =
				tprm_pkg::ST_UNAVAILABLE;
		end
		if (ctl_enter) begin
			err_next[tprm_pkg::ERR_STATE_LSB +: tprm_pkg::ERR_STATE_W] = tprm_pkg::ST_DEBUG;
		end
		if (dbg_exit) begin
			err_next[tprm_pkg::ERR_STATE_LSB +: tprm_pkg::ERR_STATE_W] = tprm_pkg::ST_IDLE;
		end else if (dbg_resume || dbg_start) begin
			err_next[tprm_pkg::ERR_STATE_LSB +: tprm_pkg::ERR_STATE_W] =
				tprm_pkg::ST_RUNNING;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			error_state_word_reg <= 16'h0000;
		end else begin
			error_state_word_reg <= err_next;
		end
	end

	// Parameter word a: shared, also takes debug examine results
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			parameter_word_a_reg <= 16'h0000;
		end else if (host_wr_ok && HOST_ACC.addr == tprm_pkg::IDX_PARAM_A) begin
			parameter_word_a_reg <= HOST_ACC.wdata; // R15 R24
		end else if (local_wr_ok && LOCAL_ACC.addr == tprm_pkg::IDX_PARAM_A) begin
			parameter_word_a_reg <= LOCAL_ACC.wdata; // R15
		end else if (DBG_RESULT_VALID) begin
			parameter_word_a_reg <= DBG_RESULT; // R6 R8
		end
	end

	// Parameter word b: reset layout carries the boot switch, plus test detail bits
	logic [DW-1:0] pb_next;
	always_comb begin
		pb_next = parameter_word_b_reg;
		if (strap_load) begin
			pb_next = 16'h0000; // R16
			pb_next[tprm_pkg::PB_SWITCH_LSB +: tprm_pkg::PB_SWITCH_W] = boot_sync_reg; // R16
		end else if (host_wr_ok && HOST_ACC.addr == tprm_pkg::IDX_PARAM_B) begin
			pb_next = HOST_ACC.wdata; // R15 R24
		end else if (local_wr_ok && LOCAL_ACC.addr == tprm_pkg::IDX_PARAM_B) begin
			pb_next = LOCAL_ACC.wdata; // R15
		end
		if (EVENTS.clk_unmasked) pb_next[tprm_pkg::DET_CLK_UNMASKED] = 1'b1; // R21
		if (EVENTS.clk_none)     pb_next[tprm_pkg::DET_CLK_NONE]     = 1'b1; // R21
		if (EVENTS.clk_stuck)    pb_next[tprm_pkg::DET_CLK_STUCK]    = 1'b1; // R21
		if (EVENTS.dma_hung)     pb_next[tprm_pkg::DET_DMA_HUNG]     = 1'b1; // R20
		if (EVENTS.dma_nxm)      pb_next[tprm_pkg::DET_DMA_NXM]      = 1'b1; // R20
		if (EVENTS.dma_data)     pb_next[tprm_pkg::DET_DMA_DATA]     = 1'b1; // R20
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			parameter_word_b_reg <= 16'h0000;
		end else begin
			parameter_word_b_reg <= pb_next;
		end
	end

	// Mailbox words four to fifteen in memory; host wins same-word writes
	wire          mb_host_we = host_wr_ok && !is_special_h;
	wire          mb_loc_we  = local_wr_ok && !is_special_l;
	wire [DW-1:0] mem_rd_h;
	wire [DW-1:0] mem_rd_l;

	tprm_regfile #(
		.WORDS (WORDS),
		.AW    (AW),
		.DW    (DW)
	) u_words (
		.clk     (SYS_CLK),
		.rst     (RST),
		.we      (mb_host_we || mb_loc_we),
		.waddr   (mb_host_we ? HOST_ACC.addr : LOCAL_ACC.addr), // R24
		.wdata   (mb_host_we ? HOST_ACC.wdata : LOCAL_ACC.wdata), // R17
		.raddr_a (HOST_ACC.addr),
		.rdata_a (mem_rd_h),
		.raddr_b (LOCAL_ACC.addr),
		.rdata_b (mem_rd_l)
	);

	// Read muxing, one cycle latency on both ports
	logic [AW-1:0] h_addr_reg;
	logic [AW-1:0] l_addr_reg;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			h_addr_reg <= '0;
			l_addr_reg <= '0;
		end else begin
			h_addr_reg <= HOST_ACC.addr;
			l_addr_reg <= LOCAL_ACC.addr;
		end
	end

	function automatic logic [DW-1:0] pick(input logic [AW-1:0] a, input logic [DW-1:0] m,
	                                      input logic [DW-1:0] c, input logic [DW-1:0] e,
	                                      input logic [DW-1:0] pa, input logic [DW-1:0] pb);
		case (a)
			tprm_pkg::IDX_COMMAND: pick = c;
			tprm_pkg::IDX_ERROR:   pick = e;
			tprm_pkg::IDX_PARAM_A: pick = pa;
			tprm_pkg::IDX_PARAM_B: pick = pb;
			default:               pick = m;
		endcase
	endfunction

	// Special words sampled alongside memory so both paths share latency
	logic [DW-1:0] cw_q_reg;
	logic [DW-1:0] ew_q_reg;
	logic [DW-1:0] pa_q_reg;
	logic [DW-1:0] pb_q_reg;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cw_q_reg <= '0;
			ew_q_reg <= '0;
			pa_q_reg <= '0;
			pb_q_reg <= '0;
		end else begin
			cw_q_reg <= command_word_reg;
			ew_q_reg <= error_state_word_reg;
			pa_q_reg <= parameter_word_a_reg;
			pb_q_reg <= parameter_word_b_reg;
		end
	end

	assign HOST_RDATA  = pick(h_addr_reg, mem_rd_h, cw_q_reg, ew_q_reg, pa_q_reg, pb_q_reg);
	assign LOCAL_RDATA = pick(l_addr_reg, mem_rd_l, cw_q_reg, ew_q_reg, pa_q_reg, pb_q_reg);

	// Mailbox doorbells: request flags stay until locally cleared; set wins
	logic [2:0] rq_set;
	always_comb begin
		rq_set[0] = mb_host_we && HOST_ACC.addr == tprm_pkg::IDX_MBOX_4; // R18
		rq_set[1] = mb_host_we && HOST_ACC.addr == tprm_pkg::IDX_MBOX_8; // R18
		rq_set[2] = mb_host_we && HOST_ACC.addr == tprm_pkg::IDX_MBOX_12; // R18
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			MBOX_RQ <= 3'h0;
		end else begin
			MBOX_RQ <= rq_set | (MBOX_RQ & ~MBOX_RQ_CLEAR); // R18
		end
	end

	// Lowest vector first when several are pending
	wire [2:0] rq_live = MBOX_RQ & MBOX_IRQ_EN;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			IRQ_REQ    <= 1'b0;
			IRQ_LEVEL  <= 3'h0;
			IRQ_VECTOR <= 9'h000;
		end else begin
			IRQ_REQ   <= |rq_live; // R18
			IRQ_LEVEL <= (|rq_live) ? tprm_pkg::IRQ_LEVEL : 3'h0;
			if (rq_live[0]) begin
				IRQ_VECTOR <= tprm_pkg::VEC_MBOX_4;
			end else if (rq_live[1]) begin
				IRQ_VECTOR <= tprm_pkg::VEC_MBOX_8;
			end else if (rq_live[2]) begin
				IRQ_VECTOR <= tprm_pkg::VEC_MBOX_12;
			end else begin
				IRQ_VECTOR <= 9'h000;
			end
		end
	end

endmodule

// [core/tprm_pkg.sv]
// Package for the two-port register mailbox: addresses, fields, codes and carriers
package tprm_pkg;

	localparam int NUM_WORDS = 16;
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 16;

	// Word indices in the file
	localparam logic [3:0] IDX_COMMAND = 4'h0;
	localparam logic [3:0] IDX_ERROR   = 4'h1;
	localparam logic [3:0] IDX_PARAM_A = 4'h2;
	localparam logic [3:0] IDX_PARAM_B = 4'h3;
	localparam logic [3:0] IDX_MBOX_4  = 4'h4;
	localparam logic [3:0] IDX_MBOX_5  = 4'h5;
	localparam logic [3:0] IDX_MBOX_8  = 4'h8;
	localparam logic [3:0] IDX_MBOX_9  = 4'h9;
	localparam logic [3:0] IDX_MBOX_12 = 4'hc;

	// Command word bits
	localparam int CMD_EXIT_BIT     = 15;
	localparam int CMD_HARD_RST_BIT = 14;
	localparam int CMD_RESUME_BIT   = 4;
	localparam int CMD_START_BIT    = 3;
	localparam int CMD_DEPOSIT_BIT  = 2;
	localparam int CMD_EX_REG_BIT   = 1;
	localparam int CMD_EX_MEM_BIT   = 0;
	localparam int CMD_CHAIN_BIT    = 1;

	// Error and state word fields
	localparam int ERR_CMD_BIT    = 15;
	localparam int ERR_XFER_BIT   = 14;
	localparam int ERR_FATAL_BIT  = 5;
	localparam int ERR_STACK_BIT  = 3;
	localparam int ERR_STATE_LSB  = 0;
	localparam int ERR_STATE_W    = 3;

	// Parameter word b reset layout and memory address widths
	localparam int PB_SWITCH_LSB = 4;
	localparam int PB_SWITCH_W   = 4;
	localparam int MEM_HI_W      = 6;
	localparam int MEM_ADDR_W    = 22;

	// Register select codes
	localparam logic [15:0] REG_CODE_MAX = 16'h0007;
	localparam logic [15:0] REG_CODE_PSW = 16'h0008;

	// Detail word bits for failed tests
	localparam int DET_CLK_UNMASKED = 1;
	localparam int DET_CLK_NONE     = 2;
	localparam int DET_CLK_STUCK    = 3;
	localparam int DET_DMA_HUNG     = 3;
	localparam int DET_DMA_NXM      = 4;
	localparam int DET_DMA_DATA     = 5;

	// Interrupt vectors, octal 120, 124 and 134
	localparam logic [8:0] VEC_MBOX_4  = 9'h050;
	localparam logic [8:0] VEC_MBOX_8  = 9'h054;
	localparam logic [8:0] VEC_MBOX_12 = 9'h05c;
	localparam logic [2:0] IRQ_LEVEL   = 3'h5;

	// Id switch values that mean standalone
	localparam logic [3:0] ID_STANDALONE_MAX = 4'h1;

	typedef enum logic [2:0] {
		ST_UNAVAILABLE = 3'h0,
		ST_SELFTEST    = 3'h1,
		ST_DEDICATED   = 3'h2,
		ST_DEBUG       = 3'h3,
		ST_IDLE        = 3'h4,
		ST_LOADING     = 3'h5,
		ST_RESERVED    = 3'h6,
		ST_RUNNING     = 3'h7
	} tprm_state_t;

	// One word access on a port
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tprm_access_t;

	// Debug action requests to the local processor
	typedef struct packed {
		logic                  exit_debug;
		logic                  resume;
		logic                  start;
		logic                  deposit;
		logic                  ex_reg;
		logic                  ex_mem;
		logic [DATA_W-1:0]     value;
		logic [DATA_W-1:0]     reg_sel;
		logic [MEM_ADDR_W-1:0] mem_addr;
	} tprm_action_t;

	// Failure and event reports from the local side
	typedef struct packed {
		logic cmd_fail;
		logic xfer_abort;
		logic fatal;
		logic stack_violation;
		logic kernel_mode;
		logic clk_unmasked;
		logic clk_none;
		logic clk_stuck;
		logic dma_hung;
		logic dma_nxm;
		logic dma_data;
	} tprm_events_t;

endpackage

// [core/tprm_regfile.sv]
// Register memory for the mailbox words, registered read ports
`timescale 1ns/10ps

module tprm_regfile #(
	parameter int WORDS = 16,
	parameter int AW    = 4,
	parameter int DW    = 16
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// Read ports
	input  wire logic [AW-1:0] raddr_a,
	output logic      [DW-1:0] rdata_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic      [DW-1:0] rdata_b
);

	logic [DW-1:0] mem_reg [WORDS];

	initial begin
		if (WORDS > (1 << AW)) begin
			$error("tprm_regfile: depth exceeds address range");
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= mem_reg[raddr_a];
			rdata_b <= mem_reg[raddr_b];
		end
	end

endmodule

// [dv/tb_top.sv]
// Self-checking bench for the two-port register mailbox
`timescale 1ns/10ps
module tb_top;
	logic                   SYS_CLK, RST, CMD_DONE, DBG_DONE, DBG_RESULT_VALID;
	logic                   STATE_SET_VALID, IRQ_REQ, HOST_HARD_RESET, DBG_CLEAR_CONTEXT;
	logic                   STANDALONE;
	logic [15:0]            DBG_RESULT, HOST_RDATA, LOCAL_RDATA, v, r, ctl;
	logic [3:0]             BOOT_SWITCH, ID_SWITCH;
	logic [2:0]             STATE_SET, MBOX_IRQ_EN, MBOX_RQ_CLEAR, MBOX_RQ, IRQ_LEVEL;
	logic [8:0]             IRQ_VECTOR;
	logic [8:0]             vec [3] = '{9'h050, 9'h054, 9'h05c};
	tprm_pkg::tprm_access_t HOST_ACC, lacc;
	tprm_pkg::tprm_action_t DBG_ACTION;
	tprm_pkg::tprm_events_t ev;
	int                     bad_count, num_checks, exp_w [16];

	tprm_host_model h (.clk(SYS_CLK), .rdata(HOST_RDATA), .acc(HOST_ACC));
	tprm_mailbox dut (.SYS_CLK, .RST, .HOST_ACC, .HOST_RDATA, .HOST_HARD_RESET,
		.LOCAL_ACC(lacc), .LOCAL_RDATA, .DBG_ACTION, .DBG_CLEAR_CONTEXT, .DBG_DONE,
		.DBG_RESULT_VALID, .DBG_RESULT, .CTRL_COMMAND(ctl), .CMD_DONE, .EVENTS(ev),
		.STATE_SET, .STATE_SET_VALID, .BOOT_SWITCH, .ID_SWITCH, .STANDALONE,
		.MBOX_IRQ_EN, .MBOX_RQ_CLEAR, .MBOX_RQ, .IRQ_REQ, .IRQ_LEVEL, .IRQ_VECTOR);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic lw(input logic [3:0] a, input logic [15:0] d);
		@(posedge SYS_CLK);
		#1 lacc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge SYS_CLK);
		#1 lacc.wr = 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	// Run needs well under a thousand cycles
	initial begin
		#400000;
		bad_count++;
		finish_test;
	end
	initial begin
		RST = 1'b1;
		lacc = '0;
		ev = '0;
		{CMD_DONE, DBG_DONE, DBG_RESULT_VALID, STATE_SET_VALID} = 4'h0;
		{DBG_RESULT, STATE_SET, MBOX_IRQ_EN, MBOX_RQ_CLEAR} = '0;
		void'($urandom(32'h346741df));
		{BOOT_SWITCH, ID_SWITCH} = 8'($urandom);
		repeat (3) @(posedge SYS_CLK);
		#1 RST = 1'b0;
		repeat (4) @(posedge SYS_CLK);
		h.rd(4'h3, v);
		chk(v, {8'h0, BOOT_SWITCH, 4'h0});
		chk(STANDALONE, ID_SWITCH <= 4'h1);
		for (int i = 1; i < 16; i++) begin
			v = (i == 1) ? 16'($urandom) & 16'h1fc0 : 16'($urandom);
			lw(4'(i), v);
			exp_w[i] = v;
		end
		for (int i = 1; i < 16; i++) begin
			v = 16'($urandom);
			h.wr(4'(i), v);
			if (!(i inside {1, 5, 9}))
				exp_w[i] = v;
		end
		fork
			h.wr(4'h6, 16'h1234);
			lw(4'h6, 16'h4321);
		join
		exp_w[6] = 16'h1234;
		for (int i = 1; i < 16; i++) begin
			h.rd(4'(i), v);
			chk(v, exp_w[i]);
		end
		chk({MBOX_RQ, IRQ_REQ}, 4'he);
		MBOX_IRQ_EN = 3'h7;
		repeat (2) @(posedge SYS_CLK);
		for (int k = 0; k < 3; k++) begin
			#1 chk({IRQ_REQ, IRQ_LEVEL, IRQ_VECTOR}, {4'hd, vec[k]});
			MBOX_RQ_CLEAR = 3'(1 << k);
			@(posedge SYS_CLK);
			#1 MBOX_RQ_CLEAR = 3'h0;
			@(posedge SYS_CLK);
		end
		#1 chk({MBOX_RQ, IRQ_REQ}, 4'h0);
		{STATE_SET, STATE_SET_VALID} = 4'h9;
		@(posedge SYS_CLK);
		#1 STATE_SET_VALID = 1'b0;
		h.wr(4'h0, 16'h0008);
		h.rd(4'h1, v);
		chk(v[2:0], 3'h3);
		h.wr(4'h3, 16'h0003);
		h.wr(4'h0, 16'h0002);
		chk({DBG_ACTION.ex_reg, DBG_ACTION.reg_sel}, 17'h10003);
		r = 16'($urandom);
		DBG_RESULT = r;
		{DBG_RESULT_VALID, DBG_DONE} = 2'h3;
		@(posedge SYS_CLK);
		#1 {DBG_RESULT_VALID, DBG_DONE} = 2'h0;
		h.rd(4'h2, v);
		chk(v, r);
		h.rd(4'h0, v);
		chk(v, 16'h0);
		h.wr(4'h3, 16'h0009);
		h.wr(4'h0, 16'h0002);
		chk(DBG_ACTION.ex_reg, 1'b0);
		h.rd(4'h1, v);
		chk(v[15], 1'b1);
		h.wr(4'h2, 16'hff25);
		h.wr(4'h3, r);
		h.wr(4'h0, 16'h0001);
		chk({DBG_ACTION.ex_mem, DBG_ACTION.mem_addr}, {1'b1, 6'h25, r});
		h.wr(4'h0, 16'h0004);
		chk({DBG_ACTION.deposit, DBG_ACTION.value}, 17'h1ff25);
		h.wr(4'h0, 16'h8010);
		chk({DBG_ACTION.exit_debug, DBG_ACTION.resume}, 2'h2);
		h.rd(4'h1, v);
		chk(v[2:0], 3'h4);
		h.wr(4'h0, 16'h0008);
		h.wr(4'h0, 16'h0010);
		chk(DBG_ACTION.resume, 1'b1);
		h.wr(4'h0, 16'h0008);
		h.wr(4'h0, 16'h0008);
		chk({DBG_ACTION.start, DBG_CLEAR_CONTEXT, DBG_ACTION.reg_sel}, {2'h3, r});
		h.rd(4'h1, v);
		chk(v[2:0], 3'h7);
		// Abort, fatal, stack and four detail events in one cycle
		ev = 11'h3b3;
		@(posedge SYS_CLK);
		#1 ev = '0;
		h.rd(4'h1, v);
		chk({v[14], v[5], v[3]}, 3'h7);
		h.rd(4'h3, v);
		chk(v, r | 16'h0036);
		h.rd(4'h1, v);
		chk(v[2:0], 3'h0);
		{STATE_SET, STATE_SET_VALID} = 4'h9;
		@(posedge SYS_CLK);
		#1 STATE_SET_VALID = 1'b0;
		h.wr(4'h0, 16'h0008);
		h.rd(4'h1, v);
		chk(v[2:0], 3'h4);
		h.wr(4'h0, 16'h4000);
		chk(HOST_HARD_RESET, 1'b1);
		@(posedge SYS_CLK);
		#1 chk(ctl, 16'h4000);
		finish_test;
	end
endmodule

// [dv/tprm_host_model.sv]
// Host arbiter model driving the host port of the mailbox
`timescale 1ns/10ps
module tprm_host_model (
	// Clock and read data
	input  wire logic                        clk,
	input  wire logic [tprm_pkg::DATA_W-1:0] rdata,
	// Host access
	output tprm_pkg::tprm_access_t           acc
);
	initial acc = '0;
	// After a write the idle port shows inverted values so a stale word is never trusted
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 acc = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 acc = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		#1 acc = '{1'b0, 1'b1, a, 16'h0};
		@(posedge clk);
		#1 d = rdata;
		acc.rd = 1'b0;
	endtask
endmodule

// [dv/tprm_mailbox_assertions.sv]
// Concurrent checks on the mailbox top-level ports
`timescale 1ns/10ps
module tprm_mailbox_assertions (
	// Clock and reset
	input wire logic                   SYS_CLK,
	input wire logic                   RST,
	// Host and debug side
	input wire tprm_pkg::tprm_access_t HOST_ACC,
	input wire tprm_pkg::tprm_action_t DBG_ACTION,
	input wire logic                   DBG_CLEAR_CONTEXT,
	input wire logic                   HOST_HARD_RESET,
	// Straps and interrupts
	input wire logic [3:0]             ID_SWITCH,
	input wire logic                   STANDALONE,
	input wire logic [2:0]             MBOX_IRQ_EN,
	input wire logic [2:0]             MBOX_RQ_CLEAR,
	input wire logic [2:0]             MBOX_RQ,
	input wire logic                   IRQ_REQ,
	input wire logic [2:0]             IRQ_LEVEL,
	input wire logic [8:0]             IRQ_VECTOR
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Strap check waits for the sync pipeline to refill after reset
	logic [2:0] up_cnt;
	logic       cmd_wr;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end
	assign cmd_wr = HOST_ACC.wr && HOST_ACC.addr == tprm_pkg::IDX_COMMAND;
	sequence s_mbox4_wr;
		HOST_ACC.wr && HOST_ACC.addr == tprm_pkg::IDX_MBOX_4 && !MBOX_RQ_CLEAR[0];
	endsequence
	sequence s_id_steady;
		(up_cnt == 3'h7 && $stable(ID_SWITCH))[*4];
	endsequence
	property p_mbox_rq; s_mbox4_wr |=> MBOX_RQ[0]; endproperty
	property p_irq4; MBOX_RQ[0] && MBOX_IRQ_EN[0] |=> IRQ_REQ && IRQ_LEVEL == 3'h5
		&& IRQ_VECTOR == tprm_pkg::VEC_MBOX_4; endproperty
	property p_irq_off; !(|(MBOX_RQ & MBOX_IRQ_EN)) |=> !IRQ_REQ; endproperty
	property p_exit_only; cmd_wr && HOST_ACC.wdata[15] |=> !(DBG_ACTION.resume
		|| DBG_ACTION.start || DBG_ACTION.deposit || DBG_ACTION.ex_reg || DBG_ACTION.ex_mem);
	endproperty
	property p_hard; cmd_wr && HOST_ACC.wdata[14] |=> HOST_HARD_RESET; endproperty
	property p_reg_sel; DBG_ACTION.ex_reg |-> DBG_ACTION.reg_sel <= 16'h0008; endproperty
	property p_mem_addr; DBG_ACTION.ex_mem |-> DBG_ACTION.mem_addr
		== {DBG_ACTION.value[5:0], DBG_ACTION.reg_sel}; endproperty
	property p_start_clr; DBG_ACTION.start |-> DBG_CLEAR_CONTEXT; endproperty
	property p_standalone; s_id_steady |-> STANDALONE == (ID_SWITCH <= 4'h1); endproperty
	a_mbox_rq: assert property (p_mbox_rq) else $error("no mailbox request");
	a_irq4: assert property (p_irq4) else $error("bad mailbox interrupt");
	a_irq_off: assert property (p_irq_off) else $error("interrupt not masked");
	a_exit_only: assert property (p_exit_only) else $error("action with exit");
	a_hard: assert property (p_hard) else $error("no hard reset");
	a_reg_sel: assert property (p_reg_sel) else $error("bad register code");
	a_mem_addr: assert property (p_mem_addr) else $error("bad memory address");
	a_start_clr: assert property (p_start_clr) else $error("no context clear");
	a_standalone: assert property (p_standalone) else $error("bad mode");
endmodule
bind tprm_mailbox tprm_mailbox_assertions u_chk (.SYS_CLK, .RST, .HOST_ACC, .DBG_ACTION,
	.DBG_CLEAR_CONTEXT, .HOST_HARD_RESET, .ID_SWITCH, .STANDALONE, .MBOX_IRQ_EN,
	.MBOX_RQ_CLEAR, .MBOX_RQ, .IRQ_REQ, .IRQ_LEVEL, .IRQ_VECTOR);
